// ==== common/rpd_pkg.sv ====
// Types shared by the reset and power-down sequencer
package rpd_pkg;

  // Main reset sequencer states
  typedef enum logic [2:0] {
    RPD_ST_PIN_RESET = 3'b000,
    RPD_ST_SOFT_RESET = 3'b001,
    RPD_ST_SETTLE = 3'b010,
    RPD_ST_READY = 3'b011,
    RPD_ST_SLEEP = 3'b100
  } rpd_state_t;

  // Per-subunit reset outputs
  typedef struct packed {
    logic pll;
    logic host_bus_interface;
    logic soft_reset_exempt;
    logic mac_interface_layer;
    logic mac;
    logic phy;
    logic eeprom_reload;
    logic strap_latch;
  } rpd_resets_t;

  // Host control strobes
  typedef struct packed {
    logic device_soft_reset_bit;
    logic pmt_phy_reset;
    logic phy_bcr_reset;
    logic byte_test_write;
    logic sleep_request;
  } rpd_host_cmd_t;

  // Status seen by the host
  typedef struct packed {
    logic ready;
    logic device_soft_reset_bit;
    logic pmt_phy_reset;
    logic phy_bcr_reset;
    logic eeprom_busy_flag;
    logic link_up;
    logic energy_on_irq_flag;
    logic irq;
  } rpd_status_t;

endpackage

// ==== common/rpd_regs.svh ====
// Timing counts and field positions for the reset and power-down sequencer
// ============================================================
// How it works
// - PHY runs energy-detect power-down only while its mode-control bit is one.
// - Powered down with no line energy, PHY keeps only management, squelch, energy logic.
// - Line energy wakes PHY, restores prior state and sets energy-on interrupt flag.
// - Energy-detected event raises a host interrupt when that interrupt is enabled.
// - First one or two packets arriving during wake-up may be dropped.
// - Pin, soft and PHY resets each reset their own set of sub-units.
// - Four reset sources: pin, device soft reset, two PHY soft reset bits.
// - Device soft reset leaves soft-reset-exempt control bits untouched.
// - After pin or soft reset, EEPROM probe runs; busy flag held until done.
// - After PHY reset, transmit waits until PHY link status is up again.
// - Ready rises about 22 ms after internal reset; host gives up at 100 ms.
// - Pin low starts hardware reset; ready reads zero until it completes.
// - Reset pin pulled high internally; unused pin means host soft resets.
// - After byte-test wake write, ready becomes one within 2 ms.
// - Device soft reset bit self-clears after about 2 us when done.
// - Power-management PHY reset bit self-clears after about 100 us when done.
// - PHY basic-control reset bit self-clears when the PHY reset completes.
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

// ============================================================
// Clock and times
`define RPD_CLK_HZ 10_000_000
`define RPD_READY_DELAY_US 22_000
`define RPD_WAKE_DELAY_US 2_000
`define RPD_SOFT_RESET_NS 2_000
`define RPD_PHY_RESET_US 100
`define RPD_PHY_REG_RESET_US 100
`define RPD_EEPROM_PROBE_US 1_000
`define RPD_READY_CYC ((`RPD_READY_DELAY_US * (`RPD_CLK_HZ / 1_000_000)))
`define RPD_WAKE_CYC ((`RPD_WAKE_DELAY_US * (`RPD_CLK_HZ / 1_000_000)))
`define RPD_SOFT_CYC ((`RPD_SOFT_RESET_NS * (`RPD_CLK_HZ / 1_000_000) + 999) / 1_000)
`define RPD_PHY_CYC ((`RPD_PHY_RESET_US * (`RPD_CLK_HZ / 1_000_000)))
`define RPD_PHY_REG_CYC ((`RPD_PHY_REG_RESET_US * (`RPD_CLK_HZ / 1_000_000)))
`define RPD_EEPROM_CYC ((`RPD_EEPROM_PROBE_US * (`RPD_CLK_HZ / 1_000_000)))

// ============================================================
// Register bit positions
`define RPD_HARDWARE_CONFIG_REG_SOFT_RESET_BIT 0
`define RPD_PMT_PHY_RESET_BIT 10
`define RPD_PHY_BCR_RESET_BIT 15
`define RPD_PHY_BSR_LINK_BIT 2
`define RPD_PHY_MCSR_EDPD_BIT 13
`define RPD_PHY_INT_ENERGY_BIT 1
`define RPD_EEPROM_BUSY_BIT 31

`endif

// ==== core/rpd_sequencer.sv ====
// Reset source sequencing and PHY energy-detect power-down control
`timescale 1ns/10ps
`include "rpd_regs.svh"

module rpd_sequencer #(
  parameter int READY_CYC = `RPD_READY_CYC,
  parameter int WAKE_CYC = `RPD_WAKE_CYC,
  parameter int SOFT_CYC = `RPD_SOFT_CYC,
  parameter int PHY_CYC = `RPD_PHY_CYC,
  parameter int PHY_REG_CYC = `RPD_PHY_REG_CYC,
  parameter int EEPROM_CYC = `RPD_EEPROM_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Reset pin, already synchronous
  input wire logic hw_reset_n_pin,
  // Host write strobes, one cycle each
  input wire rpd_pkg::rpd_host_cmd_t host_cmd,
  // Host control levels
  input wire logic edpd_enable,
  input wire logic energy_irq_enable,
  input wire logic energy_irq_clear,
  input wire logic tx_pending,
  // PHY line side
  input wire logic line_energy_present,
  input wire logic link_pulse_rx,
  input wire logic eeprom_present,
  // Subunit resets and power
  output rpd_pkg::rpd_resets_t resets,
  output logic phy_powered,
  output logic phy_tx_enable,
  output logic tx_start,
  output logic rx_drop,
  // Host status
  output rpd_pkg::rpd_status_t status
);
  import rpd_pkg::*;

  localparam int CW = 20;

  // ============================================================
  // State record
  typedef struct packed {
    rpd_state_t st;
    logic [CW-1:0] dev_cnt;
    logic [CW-1:0] phy_cnt;
    logic [CW-1:0] ee_cnt;
    logic soft_bit;
    logic pmt_phy_bit;
    logic bcr_phy_bit;
    logic ee_busy;
    logic phy_rst;
    logic phy_up;
    logic edpd_on;
    logic irq_flag;
    logic [1:0] drop_cnt;
    logic straps_done;
    rpd_resets_t rst;
  } rpd_regs_t;

  rpd_regs_t r;
  rpd_regs_t next_r;

  // Count load helper, truncated to counter width
  function automatic logic [CW-1:0] rpd_load(input int cycles);
    rpd_load = (cycles < 1) ? CW'(1) : CW'(cycles - 1);
  endfunction

  // ============================================================
  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.rst = '0;
    // Pin reset drives every subunit while the pin is held low
    if (!hw_reset_n_pin) begin
      next_r.st = RPD_ST_PIN_RESET;
      next_r.rst = '1;
      next_r.soft_bit = 1'b0;
      next_r.pmt_phy_bit = 1'b0;
      next_r.bcr_phy_bit = 1'b0;
      next_r.dev_cnt = rpd_load(READY_CYC);
      next_r.ee_cnt = rpd_load(EEPROM_CYC);
      next_r.ee_busy = 1'b1;
      next_r.phy_up = 1'b0;
      next_r.phy_rst = 1'b1;
      next_r.irq_flag = 1'b0;
      next_r.straps_done = 1'b0;
    end else begin
      case (r.st)
        RPD_ST_PIN_RESET: begin
          // Straps are caught once, after the pin is released
          next_r.rst.strap_latch = !r.straps_done;
          next_r.straps_done = 1'b1;
          // Load the settle and probe timers here too, so a power-on reset waits as long as the pin
          next_r.dev_cnt = rpd_load(READY_CYC);
          next_r.ee_cnt = rpd_load(EEPROM_CYC);
          next_r.st = RPD_ST_SETTLE;
        end
        RPD_ST_SOFT_RESET: begin
          // Only bus interface, interface layer, MAC and EEPROM reload are held
          next_r.rst.host_bus_interface = 1'b1;
          next_r.rst.mac_interface_layer = 1'b1;
          next_r.rst.mac = 1'b1;
          next_r.rst.eeprom_reload = 1'b1;
          if (r.dev_cnt == '0) begin
            next_r.soft_bit = 1'b0;
            next_r.st = RPD_ST_READY;
          end else begin
            next_r.dev_cnt = r.dev_cnt - CW'(1);
          end
        end
        RPD_ST_SETTLE, RPD_ST_SLEEP: begin
          // Ready follows the settle or wake delay
          if (r.dev_cnt == '0) begin
            next_r.st = RPD_ST_READY;
          end else begin
            next_r.dev_cnt = r.dev_cnt - CW'(1);
          end
        end
        RPD_ST_READY: begin
          // Soft reset and sleep commands only act once ready
          if (host_cmd.device_soft_reset_bit) begin
            next_r.st = RPD_ST_SOFT_RESET;
            next_r.soft_bit = 1'b1;
            next_r.dev_cnt = rpd_load(SOFT_CYC);
            next_r.ee_cnt = rpd_load(EEPROM_CYC);
            next_r.ee_busy = 1'b1;
          end else if (host_cmd.sleep_request) begin
            next_r.st = RPD_ST_SLEEP;
            next_r.dev_cnt = rpd_load(WAKE_CYC);
          end
        end
        default: begin
          next_r.st = RPD_ST_PIN_RESET;
        end
      endcase
      // Sleep holds until the byte-test write starts the wake timer
      if (r.st == RPD_ST_SLEEP) begin
        next_r.dev_cnt = r.dev_cnt;
        next_r.st = host_cmd.byte_test_write ? RPD_ST_SETTLE : RPD_ST_SLEEP;
      end
      // EEPROM probe
      if (r.ee_busy && r.st != RPD_ST_SOFT_RESET) begin
        if (r.ee_cnt == '0 || !eeprom_present) begin
          next_r.ee_busy = 1'b0;
        end else begin
          next_r.ee_cnt = r.ee_cnt - CW'(1);
        end
      end
      // PHY soft resets, writes ignored outside the ready state
      if (r.st == RPD_ST_READY && !r.phy_rst) begin
        if (host_cmd.pmt_phy_reset) begin
          next_r.pmt_phy_bit = 1'b1;
          next_r.phy_rst = 1'b1;
          next_r.phy_cnt = rpd_load(PHY_CYC);
        end else if (host_cmd.phy_bcr_reset) begin
          next_r.bcr_phy_bit = 1'b1;
          next_r.phy_rst = 1'b1;
          next_r.phy_cnt = rpd_load(PHY_REG_CYC);
        end
      end
      if (r.phy_rst) begin
        next_r.rst.phy = 1'b1;
        next_r.phy_up = 1'b0;
        if (r.phy_cnt == '0) begin
          next_r.phy_rst = 1'b0;
          next_r.pmt_phy_bit = 1'b0;
          next_r.bcr_phy_bit = 1'b0;
        end else begin
          next_r.phy_cnt = r.phy_cnt - CW'(1);
        end
      end else if (link_pulse_rx) begin
        next_r.phy_up = 1'b1;
      end
      // Energy-detect power-down; wake on line energy
      if (!edpd_enable) begin
        next_r.edpd_on = 1'b0;
      end else if (!line_energy_present) begin
        next_r.edpd_on = 1'b1;
      end else if (r.edpd_on) begin
        next_r.edpd_on = 1'b0;
        next_r.drop_cnt = 2'd2;
      end
      if (r.drop_cnt != 2'd0 && link_pulse_rx) begin
        next_r.drop_cnt = r.drop_cnt - 2'd1;
      end
      // Energy-on flag: set wins over clear
      if (r.edpd_on && edpd_enable && line_energy_present) begin
        next_r.irq_flag = 1'b1;
      end else if (energy_irq_clear) begin
        next_r.irq_flag = 1'b0;
      end
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '{st: RPD_ST_PIN_RESET, dev_cnt: '0, phy_cnt: '0, ee_cnt: '0, soft_bit: 1'b0,
             pmt_phy_bit: 1'b0, bcr_phy_bit: 1'b0, ee_busy: 1'b1, phy_rst: 1'b1, phy_up: 1'b0,
             edpd_on: 1'b0, irq_flag: 1'b0, drop_cnt: 2'd0, straps_done: 1'b0, rst: '1};
    end else begin
      r <= next_r;
    end
  end

  // ============================================================
  // Outputs
  assign resets = r.rst;
  assign phy_powered = !r.edpd_on;
  assign phy_tx_enable = !r.edpd_on && !r.phy_rst;
  assign tx_start = tx_pending && r.phy_up && !r.edpd_on;
  assign rx_drop = r.drop_cnt != 2'd0;

  // Host-visible status; ready reads zero while any device reset runs
  always_comb begin
    status.ready = (r.st == RPD_ST_READY);
    status.device_soft_reset_bit = r.soft_bit;
    status.pmt_phy_reset = r.pmt_phy_bit;
    status.phy_bcr_reset = r.bcr_phy_bit;
    status.eeprom_busy_flag = r.ee_busy;
    status.link_up = r.phy_up;
    status.energy_on_irq_flag = r.irq_flag;
    status.irq = r.irq_flag && energy_irq_enable;
  end
endmodule

// ==== test/rpd_line_model.sv ====
// Line-side partner: energy and link pulses seen by the PHY
`timescale 1ns/10ps
module rpd_line_model (
  // Clock
  input wire logic clk_sys,
  // Bench control
  input wire logic energy_on,
  // Line outputs
  output logic line_energy_present,
  output logic link_pulse_rx
);
  logic [2:0] cnt = 3'h0;
  // Pulse train every eight cycles while energy is on the line
  always @(posedge clk_sys) begin
    cnt <= cnt + 3'h1;
    line_energy_present <= energy_on;
    link_pulse_rx <= energy_on && (cnt == 3'h7);
  end
endmodule

// ==== test/rpd_sequencer_assertions.sv ====
// Checker of port timing for the reset and power-down sequencer
`timescale 1ns/10ps
module rpd_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hw_reset_n_pin,
  input wire rpd_pkg::rpd_host_cmd_t host_cmd,
  input wire logic edpd_enable,
  input wire logic energy_irq_enable,
  input wire logic line_energy_present,
  input wire rpd_pkg::rpd_resets_t resets,
  input wire logic phy_powered,
  input wire logic phy_tx_enable,
  input wire rpd_pkg::rpd_status_t status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_pin_all_resets: assert property (!hw_reset_n_pin |=> resets == 8'hFF)
    else $error("pin reset did not reset all units");
  a_pin_ready_low: assert property (!hw_reset_n_pin |=> !status.ready)
    else $error("ready high during pin reset");
  a_soft_take: assert property (host_cmd.device_soft_reset_bit && status.ready && hw_reset_n_pin
    |=> !status.ready && status.device_soft_reset_bit) else $error("soft reset not taken");
  a_soft_units: assert property (status.device_soft_reset_bit && hw_reset_n_pin
    |-> !resets.pll && !resets.soft_reset_exempt && !resets.strap_latch) else $error("soft reset hit exempt unit");
  a_soft_clear: assert property ($rose(status.device_soft_reset_bit) |-> ##[1:25] !status.device_soft_reset_bit)
    else $error("soft reset bit did not clear");
  a_phy_only: assert property (status.pmt_phy_reset && status.ready
    |-> !resets.mac && !resets.host_bus_interface && !resets.pll) else $error("phy reset hit other units");
  a_phy_clear: assert property ($rose(status.pmt_phy_reset) |-> ##[1:1000] !status.pmt_phy_reset)
    else $error("phy reset bit did not clear");
  a_edpd_down: assert property (edpd_enable && !line_energy_present |=> !phy_powered && !phy_tx_enable)
    else $error("phy powered without line energy");
  a_energy_wake: assert property (edpd_enable && !phy_powered && line_energy_present
    |-> ##[1:2] (phy_powered && status.energy_on_irq_flag)) else $error("no wake on energy");
  a_irq_gate: assert property (status.irq |-> energy_irq_enable && status.energy_on_irq_flag)
    else $error("irq without enable and flag");
  a_cmd_ignored: assert property (!status.ready && host_cmd.device_soft_reset_bit &&
    !status.device_soft_reset_bit && hw_reset_n_pin |=> !status.device_soft_reset_bit) else $error("write taken in reset");
endmodule
bind rpd_sequencer rpd_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .hw_reset_n_pin(hw_reset_n_pin),
  .host_cmd(host_cmd), .edpd_enable(edpd_enable), .energy_irq_enable(energy_irq_enable),
  .line_energy_present(line_energy_present), .resets(resets), .phy_powered(phy_powered),
  .phy_tx_enable(phy_tx_enable), .status(status));

// ==== test/testbench.sv ====
// Self-checking bench for the reset and power-down sequencer
`timescale 1ns/10ps
module testbench;
  import rpd_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hw_reset_n_pin = 1'b1;
  rpd_host_cmd_t host_cmd = '0;
  logic edpd_enable = 1'b0;
  logic energy_irq_enable = 1'b0;
  logic energy_irq_clear = 1'b0;
  logic energy_on = 1'b0;
  logic tx_pending = 1'b0;
  logic eeprom_present = 1'b1;
  logic phy_tx_enable;
  logic tx_start;
  logic rx_drop;
  logic line_energy_present;
  logic link_pulse_rx;
  rpd_resets_t resets;
  logic phy_powered;
  rpd_status_t status;
  int fail_count = 0;
  int n_compared = 0;
  int i;
  always #50 clk_sys = ~clk_sys;
  rpd_line_model u_line (.clk_sys(clk_sys), .energy_on(energy_on), .line_energy_present(line_energy_present),
    .link_pulse_rx(link_pulse_rx));
  rpd_sequencer #(.READY_CYC(40), .WAKE_CYC(30), .PHY_CYC(25), .PHY_REG_CYC(25), .EEPROM_CYC(10)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .hw_reset_n_pin(hw_reset_n_pin), .host_cmd(host_cmd),
    .edpd_enable(edpd_enable), .energy_irq_enable(energy_irq_enable), .energy_irq_clear(energy_irq_clear),
    .tx_pending(tx_pending), .line_energy_present(line_energy_present), .link_pulse_rx(link_pulse_rx),
    .eeprom_present(eeprom_present), .resets(resets), .phy_powered(phy_powered), .phy_tx_enable(phy_tx_enable),
    .tx_start(tx_start), .rx_drop(rx_drop), .status(status));
  // Compare and count
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One-cycle host write strobe
  task automatic pulse(input rpd_host_cmd_t v);
    host_cmd = v;
    cyc(1);
    host_cmd = '0;
  endtask
  task automatic wait_ready(input int n);
    for (int k = 0; k < n && status.ready !== 1'b1; k++) cyc(1);
    chk(status.ready, 1);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    test_done;
  end
  // Main sequence
  initial begin
    cyc(12);
    resetn = 1'b1;
    cyc(2);
    pulse(5'b10000);
    chk(status.device_soft_reset_bit, 0);
    chk(status.ready, 0);
    wait_ready(60);
    chk(resets, 8'h00);
    pulse(5'b10000);
    chk({status.ready, status.device_soft_reset_bit, status.eeprom_busy_flag}, 3'b011);
    cyc(2);
    chk(resets, 8'b0101_1010);
    for (i = 0; i < 25 && status.device_soft_reset_bit !== 1'b0; i++) cyc(1);
    chk(status.device_soft_reset_bit, 0);
    wait_ready(5);
    for (int p = 0; p < 2; p++) begin
      pulse(p ? 5'b00100 : 5'b01000);
      chk(p ? status.phy_bcr_reset : status.pmt_phy_reset, 1);
      cyc(1);
      chk(resets, 8'b0000_0100);
      chk({phy_tx_enable, status.link_up}, 2'b00);
      cyc(30);
      chk({status.pmt_phy_reset, status.phy_bcr_reset}, 2'b00);
    end
    hw_reset_n_pin = 1'b0;
    eeprom_present = 1'b0;
    cyc(2);
    chk(resets, 8'hFF);
    chk(status.ready, 0);
    hw_reset_n_pin = 1'b1;
    wait_ready(60);
    chk(status.eeprom_busy_flag, 0);
    eeprom_present = 1'b1;
    edpd_enable = 1'b1;
    cyc(3);
    chk(phy_powered, 0);
    energy_irq_enable = 1'b1;
    energy_on = 1'b1;
    cyc(4);
    chk({phy_powered, status.energy_on_irq_flag}, 2'b11);
    chk(status.irq, 1);
    chk(rx_drop, 1);
    energy_irq_clear = 1'b1;
    cyc(1);
    energy_irq_clear = 1'b0;
    cyc(1);
    chk(status.irq, 0);
    tx_pending = 1'b1;
    cyc(24);
    chk({tx_start, rx_drop, status.link_up, phy_tx_enable}, 4'b1011);
    tx_pending = 1'b0;
    edpd_enable = 1'b0;
    energy_on = 1'b0;
    cyc(3);
    chk(phy_powered, 1);
    pulse(5'b00001);
    cyc(1);
    chk(status.ready, 0);
    pulse(5'b00010);
    for (i = 0; i < 32 && status.ready !== 1'b1; i++) cyc(1);
    chk(status.ready, 1);
    test_done;
  end
endmodule
